// ---- tcd_consts.svh ----
// Register offsets, field positions and reset values of the timer compare block.
`ifndef TCD_CONSTS_SVH
`define TCD_CONSTS_SVH
`define TCD_ADDR_FLAGS     6'h38
`define TCD_ADDR_MASK      6'h39
`define TCD_ADDR_COUNT     6'h2E
`define TCD_ADDR_TEMP      6'h2F
`define TCD_ADDR_CMP_A     6'h30
`define TCD_ADDR_CMP_B     6'h31
`define TCD_ADDR_CMP_C     6'h32
`define TCD_ADDR_CMP_D     6'h33
`define TCD_ADDR_DEAD      6'h34
`define TCD_BIT_D          7
`define TCD_BIT_A          6
`define TCD_BIT_B          5
`define TCD_BIT_OVF        2
`define TCD_TEMP_MSB       1
`define TCD_DT_TRUE_MSB    7
`define TCD_DT_TRUE_LSB    4
`define TCD_DT_INV_MSB     3
`define TCD_DT_INV_LSB     0
`define TCD_CMP_C_MIN      10'h003
`define TCD_CMP_C_RESET    10'h3FF
`define TCD_VEC_D          10'h010
`define TCD_VEC_A          10'h003
`define TCD_VEC_B          10'h009
`define TCD_VEC_OVF        10'h004
`define TCD_VEC_NONE       10'h000
`define TCD_OWN_MASK       8'hE4
`endif

// ---- tcd_dead_timer.sv ----
// Dead-time counter in prescaled clock periods for one output edge.
`timescale 1ns/1ps
module tcd_dead_timer #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             start,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] length,
   output logic                  busy
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             busy;
   } tcd_dt_state_t;

   tcd_dt_state_t st_reg;
   tcd_dt_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (start) begin
         st_next.count = length;
         st_next.busy  = (length != '0);
      end else if (st_reg.busy && tick) begin
         st_next.count = st_reg.count - 1'b1;
         st_next.busy  = (st_reg.count != {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy = st_reg.busy;
endmodule

// ---- tcd_flag_sync.sv ----
// One sticky flag with delayed set and delayed one-write clear.
`timescale 1ns/1ps
module tcd_flag_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic set_evt,
   input  wire logic clr_write,
   input  wire logic clr_vector,
   output logic      flag
);
   typedef struct packed {
      logic set_dly;
      logic clr_dly;
      logic flag;
   } tcd_fl_state_t;

   tcd_fl_state_t st_reg;
   tcd_fl_state_t st_next;

   always_comb begin
      st_next         = st_reg;
      st_next.set_dly = set_evt;
      st_next.clr_dly = clr_write;
      // Write clear one cycle late, vector clear at once; a set wins over both.
      if (st_reg.set_dly) begin
         st_next.flag = 1'b1;
      end else if (st_reg.clr_dly || clr_vector) begin
         st_next.flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flag = st_reg.flag;
endmodule

// ---- tcd_pkg.sv ----
// Types shared by the timer compare block.
package tcd_pkg;
   typedef enum logic [1:0] {
      TCD_MODE_NORMAL,
      TCD_MODE_FAST,
      TCD_MODE_PHASE_FREQ
   } tcd_mode_t;
endpackage

// ---- tcd_timer_compare.sv ----
// Compare, interrupt flag and dead-time registers of the 10-bit timer.
`timescale 1ns/1ps
`include "tcd_consts.svh"

module tcd_timer_compare #(
   parameter int CW = 10
) (
   input  wire logic                REF_CLK,
   input  wire logic                NRST,
   input  wire logic [5:0]          ADDR,
   input  wire logic [7:0]          WDATA,
   input  wire logic                WR_EN,
   input  wire logic                RD_EN,
   input  wire logic                GLOBAL_IRQ_EN,
   input  wire logic                VECTOR_ACK,
   input  wire logic [9:0]          VECTOR_ACK_ADDR,
   input  wire logic [CW-1:0]       COUNT_IN,
   input  wire logic                COUNT_ADVANCE,
   input  wire logic                COUNT_DOWN_IN,
   input  wire logic                BOTTOM_EVT,
   input  wire logic                PRESCALE_TICK,
   input  wire tcd_pkg::tcd_mode_t  MODE,
   input  wire logic                EDGE_TRUE,
   input  wire logic                EDGE_INV,
   output logic [7:0]               RDATA,
   output logic                     COUNT_LOAD,
   output logic [CW-1:0]            COUNT_LOAD_VALUE,
   output logic                     COUNT_CLEAR,
   output logic                     COUNT_FORCE_UP,
   output logic                     MATCH_A,
   output logic                     MATCH_B,
   output logic                     MATCH_D,
   output logic [CW-1:0]            TOP_VALUE,
   output logic                     IRQ_REQ,
   output logic [9:0]               IRQ_VECTOR,
   output logic                     DEAD_TRUE_BUSY,
   output logic                     DEAD_INV_BUSY
);
   typedef struct packed {
      logic [1:0]    temp;
      logic [CW-1:0] cmp_a;
      logic [CW-1:0] cmp_b;
      logic [CW-1:0] cmp_c;
      logic [CW-1:0] cmp_d;
      logic [7:0]    mask;
      logic [7:0]    dead;
      logic [7:0]    rdata;
      logic          load;
      logic [CW-1:0] load_val;
      logic          clear;
      logic          force_up;
      logic          m_a;
      logic          m_b;
      logic          m_d;
      logic          irq;
      logic [9:0]    vec;
      logic          dt_true;
      logic          dt_inv;
   } tcd_state_t;

   tcd_state_t st_reg;
   tcd_state_t st_next;

   logic [7:0] flags;
   logic       ev_a;
   logic       ev_b;
   logic       ev_d;
   logic       ev_ovf;
   logic       wr_flags;
   logic       dt_true_busy;
   logic       dt_inv_busy;

   function automatic logic hit(input logic [7:0] a, input logic [5:0] b,
                                input logic s);
      return s && (a[5:0] == b);
   endfunction

   function automatic logic [CW-1:0] join10(input logic [1:0] hi,
                                            input logic [7:0] lo);
      return {hi, lo};
   endfunction

   // A value only matches when the engine reached it by counting.
   function automatic logic counted_to(input logic          adv,
                                       input logic [CW-1:0] cnt,
                                       input logic [CW-1:0] cmp);
      return adv && (cnt == cmp);
   endfunction

   assign wr_flags = hit({2'h0, ADDR}, `TCD_ADDR_FLAGS, WR_EN);

   // Match only while the counter advances.
   // Software writes never advance, so no match.
   assign ev_a = counted_to(COUNT_ADVANCE, COUNT_IN, st_reg.cmp_a);
   assign ev_b = counted_to(COUNT_ADVANCE, COUNT_IN, st_reg.cmp_b);
   assign ev_d = counted_to(COUNT_ADVANCE, COUNT_IN, st_reg.cmp_d);

   // Overflow at top wrap in normal and fast modes.
   // Overflow at bottom in phase-frequency mode.
   always_comb begin
      case (MODE)
         tcd_pkg::TCD_MODE_PHASE_FREQ: ev_ovf = BOTTOM_EVT;
         tcd_pkg::TCD_MODE_NORMAL,
         tcd_pkg::TCD_MODE_FAST:
            ev_ovf = counted_to(COUNT_ADVANCE, COUNT_IN, st_reg.cmp_c);
         default: ev_ovf = 1'b0;
      endcase
   end

   // Flags at bits 7, 6, 5 and overflow at bit 2.
   // Vector execution clears the matching flag.
   tcd_flag_sync u_flag_d (
      .clk        (REF_CLK),
      .rst_n      (NRST),
      .set_evt    (ev_d),
      .clr_write  (wr_flags && WDATA[`TCD_BIT_D]),
      .clr_vector (VECTOR_ACK && VECTOR_ACK_ADDR == `TCD_VEC_D),
      .flag       (flags[`TCD_BIT_D])
   );
   tcd_flag_sync u_flag_a (
      .clk        (REF_CLK),
      .rst_n      (NRST),
      .set_evt    (ev_a),
      .clr_write  (wr_flags && WDATA[`TCD_BIT_A]),
      .clr_vector (VECTOR_ACK && VECTOR_ACK_ADDR == `TCD_VEC_A),
      .flag       (flags[`TCD_BIT_A])
   );
   tcd_flag_sync u_flag_b (
      .clk        (REF_CLK),
      .rst_n      (NRST),
      .set_evt    (ev_b),
      .clr_write  (wr_flags && WDATA[`TCD_BIT_B]),
      .clr_vector (VECTOR_ACK && VECTOR_ACK_ADDR == `TCD_VEC_B),
      .flag       (flags[`TCD_BIT_B])
   );
   tcd_flag_sync u_flag_ovf (
      .clk        (REF_CLK),
      .rst_n      (NRST),
      .set_evt    (ev_ovf),
      .clr_write  (wr_flags && WDATA[`TCD_BIT_OVF]),
      .clr_vector (VECTOR_ACK && VECTOR_ACK_ADDR == `TCD_VEC_OVF),
      .flag       (flags[`TCD_BIT_OVF])
   );
   assign flags[4:3] = 2'h0;
   assign flags[1:0] = 2'h0;

   // One register feeds both dead-time counters, true and inverted.
   // Counts run on the prescaled tick, 0 to 15 periods.
   tcd_dead_timer #(.WIDTH(4)) u_dead_true (
      .clk    (REF_CLK),
      .rst_n  (NRST),
      .start  (EDGE_TRUE),
      .tick   (PRESCALE_TICK),
      .length (st_reg.dead[`TCD_DT_TRUE_MSB:`TCD_DT_TRUE_LSB]),
      .busy   (dt_true_busy)
   );
   tcd_dead_timer #(.WIDTH(4)) u_dead_inv (
      .clk    (REF_CLK),
      .rst_n  (NRST),
      .start  (EDGE_INV),
      .tick   (PRESCALE_TICK),
      .length (st_reg.dead[`TCD_DT_INV_MSB:`TCD_DT_INV_LSB]),
      .busy   (dt_inv_busy)
   );

   always_comb begin
      logic [CW-1:0] wval;
      wval             = join10(st_reg.temp, WDATA);
      st_next          = st_reg;
      st_next.load     = 1'b0;
      st_next.force_up = 1'b0;
      st_next.m_a      = ev_a;
      st_next.m_b      = ev_b;
      st_next.m_d      = ev_d;
      // Separate delays, retimed so each output leaves a flop.
      st_next.dt_true  = dt_true_busy;
      st_next.dt_inv   = dt_inv_busy;
      // Channel C match clears the counter in every mode.
      st_next.clear    = counted_to(COUNT_ADVANCE, COUNT_IN, st_reg.cmp_c);
      if (WR_EN) begin
         case (ADDR)
            // Only bits 1:0 of the temp register are kept.
            `TCD_ADDR_TEMP: st_next.temp = WDATA[`TCD_TEMP_MSB:0];
            // Low-byte write transfers all ten bits at once.
            `TCD_ADDR_COUNT: begin
               st_next.load     = 1'b1;
               st_next.load_val = wval;
               st_next.force_up = 1'b1;
            end
            // Same temp register used for every 10-bit target.
            `TCD_ADDR_CMP_A: st_next.cmp_a = wval;
            `TCD_ADDR_CMP_B: st_next.cmp_b = wval;
            // Values below three are replaced by three.
            `TCD_ADDR_CMP_C: st_next.cmp_c = (wval < `TCD_CMP_C_MIN) ?
                                             `TCD_CMP_C_MIN : wval;
            `TCD_ADDR_CMP_D: st_next.cmp_d = wval;
            `TCD_ADDR_MASK:  st_next.mask  = WDATA & `TCD_OWN_MASK;
            `TCD_ADDR_DEAD:  st_next.dead  = WDATA;
            default: ;
         endcase
      end
      st_next.rdata = 8'h00;
      if (RD_EN) begin
         case (ADDR)
            `TCD_ADDR_TEMP: st_next.rdata = {6'h00, st_reg.temp};
            // Low-byte read latches bits nine and eight.
            `TCD_ADDR_COUNT: begin
               st_next.rdata = COUNT_IN[7:0];
               st_next.temp  = COUNT_IN[CW-1:8];
            end
            // Compare reads park bits nine and eight in temp.
            `TCD_ADDR_CMP_A: begin
               st_next.rdata = st_reg.cmp_a[7:0];
               st_next.temp  = st_reg.cmp_a[CW-1:8];
            end
            `TCD_ADDR_CMP_B: begin
               st_next.rdata = st_reg.cmp_b[7:0];
               st_next.temp  = st_reg.cmp_b[CW-1:8];
            end
            `TCD_ADDR_CMP_C: begin
               st_next.rdata = st_reg.cmp_c[7:0];
               st_next.temp  = st_reg.cmp_c[CW-1:8];
            end
            `TCD_ADDR_CMP_D: begin
               st_next.rdata = st_reg.cmp_d[7:0];
               st_next.temp  = st_reg.cmp_d[CW-1:8];
            end
            `TCD_ADDR_MASK:  st_next.rdata = st_reg.mask;
            `TCD_ADDR_FLAGS: st_next.rdata = flags;
            `TCD_ADDR_DEAD:  st_next.rdata = st_reg.dead;
            default:         st_next.rdata = 8'h00;
         endcase
      end
      // Request needs global enable, mask and flag.
      // Fixed priority keeps the lowest vector first, as the core expects.
      st_next.irq = 1'b0;
      st_next.vec = `TCD_VEC_NONE;
      if (GLOBAL_IRQ_EN) begin
         // Mask bit 6 selects compare A.
         if (st_reg.mask[`TCD_BIT_A] && flags[`TCD_BIT_A]) begin
            st_next.irq = 1'b1;
            st_next.vec = `TCD_VEC_A;
         end else if (st_reg.mask[`TCD_BIT_OVF] && flags[`TCD_BIT_OVF]) begin
            st_next.irq = 1'b1;
            st_next.vec = `TCD_VEC_OVF;
         // Mask bit 5 selects compare B.
         end else if (st_reg.mask[`TCD_BIT_B] && flags[`TCD_BIT_B]) begin
            st_next.irq = 1'b1;
            st_next.vec = `TCD_VEC_B;
         // Mask bit 7 selects compare D.
         end else if (st_reg.mask[`TCD_BIT_D] && flags[`TCD_BIT_D]) begin
            st_next.irq = 1'b1;
            st_next.vec = `TCD_VEC_D;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         st_reg       <= '0;
         st_reg.cmp_c <= `TCD_CMP_C_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   logic [7:0] unused_ok;
   assign unused_ok = {7'h00, COUNT_DOWN_IN};

   assign RDATA            = st_reg.rdata;
   assign COUNT_LOAD       = st_reg.load;
   assign COUNT_LOAD_VALUE = st_reg.load_val;
   assign COUNT_CLEAR      = st_reg.clear;
   assign COUNT_FORCE_UP   = st_reg.force_up;
   assign MATCH_A          = st_reg.m_a;
   assign MATCH_B          = st_reg.m_b;
   assign MATCH_D          = st_reg.m_d;
   assign TOP_VALUE        = st_reg.cmp_c;
   assign IRQ_REQ          = st_reg.irq;
   assign IRQ_VECTOR       = st_reg.vec;
   assign DEAD_TRUE_BUSY   = st_reg.dt_true;
   assign DEAD_INV_BUSY    = st_reg.dt_inv;
endmodule

// ---- tcd_timer_compare_bench.sv ----
// Self-checking bench for the timer compare, flag and dead-time block.
`timescale 1ns/1ps
`include "tcd_consts.svh"
module tcd_timer_compare_bench;
   logic               REF_CLK = 1'b0;
   logic               NRST = 1'b0;
   logic [5:0]         ADDR = 6'h00;
   logic [7:0]         WDATA = 8'h00;
   logic               WR_EN = 1'b0;
   logic               RD_EN = 1'b0;
   logic               GLOBAL_IRQ_EN = 1'b0;
   logic               VECTOR_ACK = 1'b0;
   logic [9:0]         VECTOR_ACK_ADDR = 10'h000;
   logic [9:0]         COUNT_IN = 10'h000;
   logic               COUNT_ADVANCE = 1'b0;
   logic               BOTTOM_EVT = 1'b0;
   logic               PRESCALE_TICK = 1'b0;
   tcd_pkg::tcd_mode_t MODE = tcd_pkg::TCD_MODE_NORMAL;
   logic               EDGE_TRUE = 1'b0;
   logic               EDGE_INV = 1'b0;
   logic [7:0]         RDATA;
   logic [9:0]         COUNT_LOAD_VALUE, TOP_VALUE, IRQ_VECTOR;
   logic               COUNT_LOAD, COUNT_CLEAR, COUNT_FORCE_UP, IRQ_REQ;
   logic               MATCH_A, MATCH_B, MATCH_D;
   logic               DEAD_TRUE_BUSY, DEAD_INV_BUSY;
   int                 mismatches = 0;
   int                 n_compared = 0;
   tcd_timer_compare i_dut (
      .REF_CLK, .NRST, .ADDR, .WDATA, .WR_EN, .RD_EN, .GLOBAL_IRQ_EN,
      .VECTOR_ACK, .VECTOR_ACK_ADDR, .COUNT_IN, .COUNT_ADVANCE,
      .COUNT_DOWN_IN(1'b0), .BOTTOM_EVT, .PRESCALE_TICK, .MODE,
      .EDGE_TRUE, .EDGE_INV, .RDATA, .COUNT_LOAD, .COUNT_LOAD_VALUE,
      .COUNT_CLEAR, .COUNT_FORCE_UP, .MATCH_A, .MATCH_B, .MATCH_D,
      .TOP_VALUE, .IRQ_REQ, .IRQ_VECTOR, .DEAD_TRUE_BUSY, .DEAD_INV_BUSY);
   always #20 REF_CLK = ~REF_CLK;
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge REF_CLK);
      ADDR = a;
      WDATA = d;
      WR_EN = 1'b1;
      @(negedge REF_CLK);
      WR_EN = 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge REF_CLK);
      ADDR = a;
      RD_EN = 1'b1;
      @(negedge REF_CLK);
      RD_EN = 1'b0;
      chk({2'b00, RDATA}, {2'b00, e});
   endtask
   task automatic cnt(input logic [9:0] v);
      @(negedge REF_CLK);
      COUNT_IN = v;
      COUNT_ADVANCE = 1'b1;
      @(negedge REF_CLK);
      COUNT_ADVANCE = 1'b0;
   endtask
   task automatic dead(input logic [7:0] dt, input int et, input int ei);
      int nt;
      int ni;
      nt = 0;
      ni = 0;
      wr(`TCD_ADDR_DEAD, dt);
      rd(`TCD_ADDR_DEAD, dt);
      PRESCALE_TICK = 1'b1;
      EDGE_TRUE = 1'b1;
      EDGE_INV = 1'b1;
      @(negedge REF_CLK);
      EDGE_TRUE = 1'b0;
      EDGE_INV = 1'b0;
      repeat (20) begin
         nt += int'(DEAD_TRUE_BUSY);
         ni += int'(DEAD_INV_BUSY);
         @(negedge REF_CLK);
      end
      PRESCALE_TICK = 1'b0;
      chk(nt[9:0], et[9:0]);
      chk(ni[9:0], ei[9:0]);
   endtask
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // The span allows the whole sequence about four times over.
   initial begin
      #30000;
      mismatches++;
      end_of_test;
   end
   initial begin
      tick(10);
      NRST = 1'b1;
      chk(TOP_VALUE, 10'h3FF);
      rd(`TCD_ADDR_FLAGS, 8'h00);
      wr(`TCD_ADDR_TEMP, 8'h00);
      wr(`TCD_ADDR_CMP_C, 8'h01);
      chk(TOP_VALUE, 10'h003);
      rd(`TCD_ADDR_CMP_C, 8'h03);
      wr(`TCD_ADDR_MASK, 8'hFF);
      rd(`TCD_ADDR_MASK, 8'hE4);
      wr(6'h3F, 8'hFF);
      rd(6'h3F, 8'h00);
      wr(`TCD_ADDR_TEMP, 8'h02);
      wr(`TCD_ADDR_CMP_C, 8'h00);
      chk(TOP_VALUE, 10'h200);
      $display("Test registers done");
      wr(`TCD_ADDR_TEMP, 8'h01);
      wr(`TCD_ADDR_CMP_A, 8'h20);
      wr(`TCD_ADDR_TEMP, 8'h00);
      rd(`TCD_ADDR_CMP_A, 8'h20);
      rd(`TCD_ADDR_TEMP, 8'h01);
      GLOBAL_IRQ_EN = 1'b1;
      cnt(10'h120);
      chk({9'h000, MATCH_A}, 10'h001);
      chk({9'h000, IRQ_REQ}, 10'h000);
      tick(2);
      chk(IRQ_VECTOR, 10'h003);
      rd(`TCD_ADDR_FLAGS, 8'h40);
      VECTOR_ACK = 1'b1;
      VECTOR_ACK_ADDR = 10'h003;
      tick(1);
      VECTOR_ACK = 1'b0;
      tick(1);
      chk({9'h000, IRQ_REQ}, 10'h000);
      rd(`TCD_ADDR_FLAGS, 8'h00);
      $display("Test match A done");
      wr(`TCD_ADDR_TEMP, 8'h00);
      wr(`TCD_ADDR_CMP_D, 8'h05);
      wr(`TCD_ADDR_CMP_B, 8'h06);
      cnt(10'h005);
      chk({9'h000, MATCH_D}, 10'h001);
      cnt(10'h006);
      chk({9'h000, MATCH_B}, 10'h001);
      tick(2);
      rd(`TCD_ADDR_FLAGS, 8'hA0);
      chk(IRQ_VECTOR, 10'h009);
      wr(`TCD_ADDR_FLAGS, 8'h00);
      rd(`TCD_ADDR_FLAGS, 8'hA0);
      wr(`TCD_ADDR_FLAGS, 8'h20);
      tick(2);
      rd(`TCD_ADDR_FLAGS, 8'h80);
      chk(IRQ_VECTOR, 10'h010);
      wr(`TCD_ADDR_FLAGS, 8'h80);
      tick(2);
      rd(`TCD_ADDR_FLAGS, 8'h00);
      COUNT_IN = 10'h005;
      wr(`TCD_ADDR_COUNT, 8'h05);
      chk({9'h000, COUNT_LOAD}, 10'h001);
      chk({9'h000, COUNT_FORCE_UP}, 10'h001);
      tick(3);
      rd(`TCD_ADDR_FLAGS, 8'h00);
      chk(COUNT_LOAD_VALUE, 10'h005);
      COUNT_IN = 10'h2A5;
      rd(`TCD_ADDR_COUNT, 8'hA5);
      rd(`TCD_ADDR_TEMP, 8'h02);
      $display("Test flags done");
      for (int i = 0; i < 2; i++) begin
         MODE = tcd_pkg::tcd_mode_t'(i);
         cnt(10'h200);
         chk({9'h000, COUNT_CLEAR}, 10'h001);
         tick(2);
         rd(`TCD_ADDR_FLAGS, 8'h04);
         chk(IRQ_VECTOR, 10'h004);
         wr(`TCD_ADDR_FLAGS, 8'h04);
         tick(2);
      end
      MODE = tcd_pkg::TCD_MODE_PHASE_FREQ;
      cnt(10'h200);
      chk({9'h000, COUNT_CLEAR}, 10'h001);
      tick(2);
      rd(`TCD_ADDR_FLAGS, 8'h00);
      BOTTOM_EVT = 1'b1;
      tick(1);
      BOTTOM_EVT = 1'b0;
      tick(2);
      rd(`TCD_ADDR_FLAGS, 8'h04);
      chk({9'h000, IRQ_REQ}, 10'h001);
      GLOBAL_IRQ_EN = 1'b0;
      tick(2);
      chk({9'h000, IRQ_REQ}, 10'h000);
      chk(IRQ_VECTOR, 10'h000);
      GLOBAL_IRQ_EN = 1'b1;
      wr(`TCD_ADDR_MASK, 8'hE0);
      tick(1);
      chk({9'h000, IRQ_REQ}, 10'h000);
      $display("Test overflow done");
      dead(8'h21, 2, 1);
      dead(8'hF0, 15, 0);
      $display("Test dead time done");
      end_of_test;
   end
endmodule

// ---- tcd_timer_compare_sva.sv ----
// Port checker for the timer compare, flag and dead-time block.
`timescale 1ns/1ps
`include "tcd_consts.svh"
module tcd_timer_compare_chk #(
   parameter int CW = 10
) (
   input wire logic          REF_CLK,
   input wire logic          NRST,
   input wire logic [5:0]    ADDR,
   input wire logic [7:0]    WDATA,
   input wire logic          WR_EN,
   input wire logic          RD_EN,
   input wire logic          GLOBAL_IRQ_EN,
   input wire logic [CW-1:0] COUNT_IN,
   input wire logic          COUNT_ADVANCE,
   input wire logic [7:0]    RDATA,
   input wire logic          COUNT_LOAD,
   input wire logic [CW-1:0] COUNT_LOAD_VALUE,
   input wire logic          COUNT_CLEAR,
   input wire logic          COUNT_FORCE_UP,
   input wire logic          MATCH_A,
   input wire logic [CW-1:0] TOP_VALUE,
   input wire logic          IRQ_REQ,
   input wire logic [9:0]    IRQ_VECTOR
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   sequence s_temp_zero;
      WR_EN && !RD_EN && ADDR == `TCD_ADDR_TEMP && WDATA == 8'h00;
   endsequence
   // Any read of a 10-bit register reloads temp, so none may intervene.
   sequence s_temp_kept;
      !RD_EN && !(WR_EN && ADDR == `TCD_ADDR_TEMP);
   endsequence
   sequence s_low_small;
      WR_EN && ADDR == `TCD_ADDR_CMP_C && WDATA < 8'h03;
   endsequence
   property p_cmp_c_min;
      s_temp_zero ##1 s_temp_kept ##1 s_low_small |=> TOP_VALUE == 10'h003;
   endproperty
   a_cmp_c_min: assert property (p_cmp_c_min)
      else $error("Small top value was not raised to three.");
   property p_top_floor;
      TOP_VALUE >= 10'h003;
   endproperty
   a_top_floor: assert property (p_top_floor)
      else $error("Top value below three.");
   property p_match_a;
      MATCH_A |-> $past(COUNT_ADVANCE);
   endproperty
   a_match_a: assert property (p_match_a)
      else $error("Match without counting.");
   property p_clear;
      COUNT_ADVANCE && COUNT_IN == TOP_VALUE |=> COUNT_CLEAR;
   endproperty
   a_clear: assert property (p_clear)
      else $error("Top match did not clear the counter.");
   property p_force_up;
      COUNT_LOAD |-> COUNT_FORCE_UP;
   endproperty
   a_force_up: assert property (p_force_up)
      else $error("Counter load without upward direction.");
   property p_load;
      WR_EN && ADDR == `TCD_ADDR_COUNT
         |=> COUNT_LOAD && COUNT_LOAD_VALUE[7:0] == $past(WDATA);
   endproperty
   a_load: assert property (p_load)
      else $error("Counter write not passed on.");
   property p_irq_gate;
      !GLOBAL_IRQ_EN [*2] |-> !IRQ_REQ;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("Interrupt with global enable off.");
   property p_rdata_idle;
      !$past(RD_EN) |-> RDATA == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("Read data not zero outside a read.");
   property p_vec_valid;
      IRQ_REQ |-> IRQ_VECTOR inside {10'h003, 10'h004, 10'h009, 10'h010};
   endproperty
   a_vec_valid: assert property (p_vec_valid)
      else $error("Unknown interrupt vector.");
endmodule
bind tcd_timer_compare tcd_timer_compare_chk #(.CW(CW)) i_chk (
   .REF_CLK, .NRST, .ADDR, .WDATA, .WR_EN, .RD_EN, .GLOBAL_IRQ_EN,
   .COUNT_IN, .COUNT_ADVANCE, .RDATA, .COUNT_LOAD, .COUNT_LOAD_VALUE,
   .COUNT_CLEAR, .COUNT_FORCE_UP, .MATCH_A, .TOP_VALUE, .IRQ_REQ,
   .IRQ_VECTOR);
